// ### rtl/ber_window_counter.sv
`default_nettype none
`include "lt_coef_params.svh"

module ber_window_counter (
    input  wire logic                       clock_in,
    input  wire logic                       resetn_in,
    input  wire logic                       step_start_in,
    input  wire logic                       frame_in,
    input  wire lt_types_pkg::window_scale_t scale_in,
    input  wire logic [9:0]                 count_in,
    output logic                            busy_out,
    output logic                            window_done_out
);

    lt_types_pkg::window_state_t state_reg, state_next;
    lt_types_pkg::window_scale_t scale_reg, scale_next;
    logic [19:0]                 pre_reg, pre_next;
    logic [9:0]                  units_reg, units_next;
    logic [9:0]                  target_reg, target_next;
    logic                        done_reg, done_next;
    logic [19:0]                 unit_last;

    always_comb begin
        case (scale_reg)
            lt_types_pkg::SCALE_MEGA: unit_last = `MEGA_LAST;
            lt_types_pkg::SCALE_KILO: unit_last = `KILO_LAST;
            default:                  unit_last = `FRAME_LAST;
        endcase
    end

    always_comb begin
        state_next  = state_reg;
        scale_next  = scale_reg;
        pre_next    = pre_reg;
        units_next  = units_reg;
        target_next = target_reg;
        done_next   = 1'b0;
        // Settings are latched so a mid-step write cannot stretch a window
        if (step_start_in) begin
            state_next  = lt_types_pkg::WIN_COUNT;
            scale_next  = scale_in;
            pre_next    = 20'h00000;
            units_next  = 10'h000;
            target_next = (count_in == 10'h000) ? 10'h001 : count_in;
        end else begin
            case (state_reg)
                lt_types_pkg::WIN_IDLE: begin
                    state_next = lt_types_pkg::WIN_IDLE;
                end
                lt_types_pkg::WIN_COUNT: begin
                    if (frame_in) begin
                        if (pre_reg == unit_last) begin
                            pre_next   = 20'h00000;
                            units_next = units_reg + 10'h001;
                            if (units_next == target_reg) begin
                                done_next  = 1'b1;
                                state_next = lt_types_pkg::WIN_IDLE;
                            end
                        end else begin
                            pre_next = pre_reg + 20'h00001;
                        end
                    end
                end
                default: state_next = lt_types_pkg::WIN_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_reg  <= lt_types_pkg::WIN_IDLE;
            scale_reg  <= lt_types_pkg::SCALE_FRAMES;
            pre_reg    <= 20'h00000;
            units_reg  <= 10'h000;
            target_reg <= 10'h001;
            done_reg   <= 1'b0;
        end else begin
            state_reg  <= state_next;
            scale_reg  <= scale_next;
            pre_reg    <= pre_next;
            units_reg  <= units_next;
            target_reg <= target_next;
            done_reg   <= done_next;
        end
    end

    assign busy_out        = (state_reg == lt_types_pkg::WIN_COUNT);
    assign window_done_out = done_reg;

endmodule

`default_nettype wire

// ### rtl/coef_request_decode.sv
`default_nettype none
`include "lt_coef_params.svh"

module coef_request_decode (
    input  wire logic [5:0] request_in,
    output logic      [2:0] tap_inc_out,
    output logic      [2:0] tap_dec_out,
    output logic            reserved_out
);

    logic [2:0] tap_rsvd;

    // Tap 0 is pre, 1 is main, 2 is post
    genvar t;
    generate
        for (t = 0; t < 3; t++) begin : g_tap
            assign tap_inc_out[t] = (request_in[2*t +: 2] == `TAP_INC);
            assign tap_dec_out[t] = (request_in[2*t +: 2] == `TAP_DEC);
            assign tap_rsvd[t]    = (request_in[2*t +: 2] == `TAP_RSVD);
        end
    endgenerate

    assign reserved_out = |tap_rsvd;

endmodule

`default_nettype wire

// ### rtl/link_training_ber_and_coef_regs.sv
`default_nettype none
`include "lt_coef_params.svh"

// How it works
// - Ten-bit thousands field sets thousands of frames checked per equalization step while millions is zero.
// - Thousands field resets to 0x15 in hardware builds, zero in simulation.
// - Ten-bit millions field sets millions of frames checked per equalization step.
// - Six-bit local request field mirrors the first transmitted training word.
// - Local request fields are read-only unless coefficient override is enabled.
// - Each two-bit tap request: 00 hold, 01 increment, 10 decrement, 11 reserved.
// - Initialize request bit asks the partner to initialize its equalizer.
// - Preset request bit asks the partner to switch equalization off.
// - Read-only local report field shows the second word last transmitted.
// - Raw frame-count field sets the window only while thousands and millions are both zero.
module link_training_ber_and_coef_regs #(
    parameter bit SIM_BUILD = 1'b0
) (
    input  wire logic        clock_in,
    input  wire logic        resetn_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    input  wire logic [3:0]  pstrb_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic [5:0]  engine_coef_request_in,
    input  wire logic        engine_init_request_in,
    input  wire logic        engine_preset_request_in,
    input  wire logic        frame_sent_in,
    input  wire logic [5:0]  sent_report_in,
    input  wire logic        step_start_in,
    input  wire logic        rx_frame_in,
    output logic      [5:0]  coef_request_out,
    output logic             init_request_out,
    output logic             preset_request_out,
    output logic             override_enable_out,
    output logic      [2:0]  tap_inc_out,
    output logic      [2:0]  tap_dec_out,
    output logic             request_reserved_out,
    output logic      [1:0]  window_scale_out,
    output logic      [9:0]  window_count_out,
    output logic             window_busy_out,
    output logic             window_done_out
);

    localparam logic [9:0] K_RESET   = SIM_BUILD ? `K_RESET_SIM : `K_RESET_HW;
    localparam logic [9:0] RAW_RESET = SIM_BUILD ? `RAW_RESET_SIM : `RAW_RESET_HW;

    logic                        override_reg, override_next;
    logic [9:0]                  raw_reg, raw_next;
    logic [9:0]                  k_reg, k_next;
    logic [9:0]                  m_reg, m_next;
    logic [5:0]                  req_reg, req_next;
    logic                        init_reg, init_next;
    logic                        preset_reg, preset_next;
    logic [5:0]                  rpt_reg, rpt_next;
    lt_types_pkg::window_scale_t eff_scale_reg, eff_scale_next;
    logic [9:0]                  eff_count_reg, eff_count_next;
    logic [31:0]                 prdata_reg, prdata_next;

    logic [9:0]  word_idx;
    logic        mapped;
    logic        setup_phase;
    logic        wr_take;
    logic        wr_ctrl;
    logic        wr_window;
    logic        wr_coef;
    logic [31:0] wmask;
    logic [31:0] ctrl_word;
    logic [31:0] window_word;
    logic [31:0] coef_word;
    logic [31:0] rd_word;
    logic [31:0] ctrl_merged;
    logic [31:0] window_merged;
    logic [31:0] coef_merged;

    // Bus decode
    assign word_idx    = paddr_in[11:2];
    assign mapped      = (word_idx == `CTRL_IDX) || (word_idx == `WINDOW_IDX) || (word_idx == `COEF_IDX);
    assign setup_phase = psel_in && !penable_in;
    // No wait states: read data is caught in the setup cycle
    assign pready_out  = 1'b1;
    assign pslverr_out = psel_in && penable_in && !mapped;
    assign wr_take     = psel_in && penable_in && pwrite_in && pready_out;
    assign wr_ctrl     = wr_take && (word_idx == `CTRL_IDX);
    assign wr_window   = wr_take && (word_idx == `WINDOW_IDX);
    assign wr_coef     = wr_take && (word_idx == `COEF_IDX);

    genvar b;
    generate
        for (b = 0; b < 4; b++) begin : g_lane
            assign wmask[8*b +: 8] = {8{pstrb_in[b]}};
        end
    endgenerate

    always_comb begin
        ctrl_word            = 32'h00000000;
        ctrl_word[`OVRD_BIT] = override_reg;
    end

    assign window_word   = {2'h0, m_reg, k_reg, raw_reg};
    assign coef_word     = {18'h00000, rpt_reg, preset_reg, init_reg, req_reg};
    assign ctrl_merged   = (ctrl_word & ~wmask) | (pwdata_in & wmask);
    assign window_merged = (window_word & ~wmask) | (pwdata_in & wmask);
    assign coef_merged   = (coef_word & ~wmask) | (pwdata_in & wmask);

    always_comb begin
        case (word_idx)
            `CTRL_IDX:   rd_word = ctrl_word;
            `WINDOW_IDX: rd_word = window_word;
            `COEF_IDX:   rd_word = coef_word;
            default:     rd_word = 32'h00000000;
        endcase
    end

    always_comb begin
        prdata_next = prdata_reg;
        if (setup_phase && !pwrite_in) begin
            prdata_next = rd_word;
        end
    end

    // Configuration registers
    always_comb begin
        override_next = override_reg;
        raw_next      = raw_reg;
        k_next        = k_reg;
        m_next        = m_reg;
        if (wr_ctrl) begin
            override_next = ctrl_merged[`OVRD_BIT];
        end
        if (wr_window) begin
            raw_next = window_merged[`RAW_MSB:`RAW_LSB];
            k_next   = window_merged[`K_MSB:`K_LSB];
            m_next   = window_merged[`M_MSB:`M_LSB];
        end
    end

    // Local request follows the engine unless software overrides it
    always_comb begin
        req_next    = req_reg;
        init_next   = init_reg;
        preset_next = preset_reg;
        rpt_next    = rpt_reg;
        if (!override_reg) begin
            req_next    = engine_coef_request_in;
            init_next   = engine_init_request_in;
            preset_next = engine_preset_request_in;
        end else if (wr_coef) begin
            req_next    = coef_merged[`REQ_MSB:`REQ_LSB];
            init_next   = coef_merged[`INIT_BIT];
            preset_next = coef_merged[`PRESET_BIT];
        end
        if (frame_sent_in) begin
            rpt_next = sent_report_in;
        end
    end

    // Millions wins over thousands; raw count only when both are zero
    always_comb begin
        if (m_reg != 10'h000) begin
            eff_scale_next = lt_types_pkg::SCALE_MEGA;
            eff_count_next = m_reg;
        end else if (k_reg != 10'h000) begin
            eff_scale_next = lt_types_pkg::SCALE_KILO;
            eff_count_next = k_reg;
        end else begin
            eff_scale_next = lt_types_pkg::SCALE_FRAMES;
            eff_count_next = raw_reg;
        end
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            override_reg  <= 1'b0;
            raw_reg       <= RAW_RESET;
            k_reg         <= K_RESET;
            m_reg         <= `M_RESET;
            req_reg       <= 6'h00;
            init_reg      <= 1'b0;
            preset_reg    <= 1'b0;
            rpt_reg       <= 6'h00;
            eff_scale_reg <= lt_types_pkg::SCALE_FRAMES;
            eff_count_reg <= 10'h000;
            prdata_reg    <= 32'h00000000;
        end else begin
            override_reg  <= override_next;
            raw_reg       <= raw_next;
            k_reg         <= k_next;
            m_reg         <= m_next;
            req_reg       <= req_next;
            init_reg      <= init_next;
            preset_reg    <= preset_next;
            rpt_reg       <= rpt_next;
            eff_scale_reg <= eff_scale_next;
            eff_count_reg <= eff_count_next;
            prdata_reg    <= prdata_next;
        end
    end

    assign prdata_out          = prdata_reg;
    assign coef_request_out    = req_reg;
    assign init_request_out    = init_reg;
    assign preset_request_out  = preset_reg;
    assign override_enable_out = override_reg;
    assign window_scale_out    = eff_scale_reg;
    assign window_count_out    = eff_count_reg;

    coef_request_decode u_decode (
        .request_in   (req_reg),
        .tap_inc_out  (tap_inc_out),
        .tap_dec_out  (tap_dec_out),
        .reserved_out (request_reserved_out)
    );

    ber_window_counter u_window (
        .clock_in        (clock_in),
        .resetn_in       (resetn_in),
        .step_start_in   (step_start_in),
        .frame_in        (rx_frame_in),
        .scale_in        (eff_scale_reg),
        .count_in        (eff_count_reg),
        .busy_out        (window_busy_out),
        .window_done_out (window_done_out)
    );

    // Checks
    logic first_cycle_reg;

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            first_cycle_reg <= 1'b1;
        end else begin
            first_cycle_reg <= 1'b0;
        end
    end

    default clocking cb @(posedge clock_in);
    endclocking

    default disable iff (!resetn_in);

    a_k_field_write: assert property (
        wr_window && (pstrb_in == 4'hF) |=> k_reg == $past(pwdata_in[19:10])
    ) else $error("thousands field did not take the written value");

    a_k_reset_value: assert property (
        first_cycle_reg |-> (k_reg == K_RESET) && (raw_reg == RAW_RESET)
    ) else $error("window fields wrong after reset");

    a_m_field_write: assert property (
        wr_window && (pstrb_in == 4'hF) |=> m_reg == $past(pwdata_in[29:20])
    ) else $error("millions field did not take the written value");

    a_req_mirror: assert property (
        !override_reg |=> coef_request_out == $past(engine_coef_request_in)
    ) else $error("request field does not mirror the engine");

    a_req_locked: assert property (
        override_reg && !wr_coef ##1 override_reg |-> $stable(coef_request_out)
    ) else $error("overridden request changed without a write");

    a_req_sw_write: assert property (
        override_reg && wr_coef && pstrb_in[0] |=> coef_request_out == $past(pwdata_in[5:0])
    ) else $error("override write not applied to request field");

    a_tap_decode: assert property (
        coef_request_out[5:4] == `TAP_DEC |-> tap_dec_out[2] && !tap_inc_out[2]
    ) else $error("post tap decrement decoded wrongly");

    a_init_request: assert property (
        override_reg && wr_coef && pstrb_in[0] |=> init_request_out == $past(pwdata_in[6])
    ) else $error("initialize request not taken from software");

    a_preset_mirror: assert property (
        !override_reg |=> preset_request_out == $past(engine_preset_request_in)
    ) else $error("preset request does not follow the engine");

    a_report_update: assert property (
        frame_sent_in ##1 !frame_sent_in |-> rpt_reg == $past(sent_report_in) ##1 $stable(rpt_reg)
    ) else $error("report field not held from last sent frame");

    a_raw_window: assert property (
        !first_cycle_reg && (k_reg == 10'h000) && (m_reg == 10'h000) |=>
            (window_scale_out == lt_types_pkg::SCALE_FRAMES) && (window_count_out == $past(raw_reg))
    ) else $error("raw count not used while thousands is zero");

    a_k_hold: assert property (
        !wr_window |=> $stable(k_reg)
    ) else $error("thousands field changed without a write");

    a_m_hold: assert property (
        !wr_window |=> $stable(m_reg)
    ) else $error("millions field changed without a write");

    a_kilo_select: assert property (
        !first_cycle_reg && (m_reg == 10'h000) && (k_reg != 10'h000) |=>
            (window_scale_out == lt_types_pkg::SCALE_KILO) && (window_count_out == $past(k_reg))
    ) else $error("thousands field not used for the window");

    a_mega_select: assert property (
        (m_reg != 10'h000) |=>
            (window_scale_out == lt_types_pkg::SCALE_MEGA) && (window_count_out == $past(m_reg))
    ) else $error("millions field not used for the window");

    a_init_mirror: assert property (
        !first_cycle_reg && !override_reg |=> init_request_out == $past(engine_init_request_in)
    ) else $error("initialize request does not follow the engine");

    a_init_locked: assert property (
        override_reg && !wr_coef |=> $stable(init_request_out)
    ) else $error("initialize request changed without a write");

    a_preset_write: assert property (
        override_reg && wr_coef && pstrb_in[0] |=> preset_request_out == $past(pwdata_in[7])
    ) else $error("preset request not taken from software");

    a_pre_tap_inc: assert property (
        coef_request_out[1:0] == `TAP_INC |-> tap_inc_out[0] && !tap_dec_out[0]
    ) else $error("pre tap increment decoded wrongly");

    a_main_tap_rsvd: assert property (
        coef_request_out[3:2] == `TAP_RSVD |-> request_reserved_out && !tap_inc_out[1] && !tap_dec_out[1]
    ) else $error("main tap reserved code decoded wrongly");

    a_report_hold: assert property (
        !frame_sent_in |=> $stable(rpt_reg)
    ) else $error("report field changed without a sent frame");

    a_coef_readback: assert property (
        setup_phase && !pwrite_in && (word_idx == `COEF_IDX) |=> prdata_out == $past(coef_word)
    ) else $error("local coefficient word read back wrongly");

    c_override_write: cover property (override_reg && wr_coef);
    c_frame_sent:     cover property (frame_sent_in ##1 frame_sent_in);
    c_window_done:    cover property (step_start_in ##[1:20] window_done_out);
    c_unmapped:       cover property (pslverr_out);
    c_kilo_start:     cover property (step_start_in && (window_scale_out == lt_types_pkg::SCALE_KILO));

endmodule

`default_nettype wire

// ### rtl/lt_coef_params.svh
`ifndef LT_COEF_PARAMS_SVH
`define LT_COEF_PARAMS_SVH

// Register word indices, byte address is index times four
`define CTRL_IDX        10'h0D0
`define WINDOW_IDX      10'h0D3
`define COEF_IDX        10'h0D4

// Control register fields
`define OVRD_BIT        16

// Error window register fields
`define RAW_LSB         0
`define RAW_MSB         9
`define K_LSB           10
`define K_MSB           19
`define M_LSB           20
`define M_MSB           29

// Local coefficient register fields
`define REQ_LSB         0
`define REQ_MSB         5
`define INIT_BIT        6
`define PRESET_BIT      7
`define RPT_LSB         8
`define RPT_MSB         13

// Reset values
`define K_RESET_HW      10'h015
`define K_RESET_SIM     10'h000
`define RAW_RESET_HW    10'h000
`define RAW_RESET_SIM   10'h003
`define M_RESET         10'h000

// Request subfield encoding
`define TAP_HOLD        2'h0
`define TAP_INC         2'h1
`define TAP_DEC         2'h2
`define TAP_RSVD        2'h3

// Frames per counting unit, minus one
`define FRAME_LAST      20'h00000
`define KILO_LAST       20'h003E7
`define MEGA_LAST       20'hF423F

`endif

// ### rtl/lt_types_pkg.sv
`default_nettype none

package lt_types_pkg;

    typedef enum logic [1:0] {
        SCALE_FRAMES,
        SCALE_KILO,
        SCALE_MEGA
    } window_scale_t;

    typedef enum logic {
        WIN_IDLE,
        WIN_COUNT
    } window_state_t;

endpackage

`default_nettype wire

// ### verification/testbench.sv
`default_nettype none
`include "lt_coef_params.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] A_CTL = {`CTRL_IDX, 2'h0};
    localparam logic [11:0] A_WIN = {`WINDOW_IDX, 2'h0};
    localparam logic [11:0] A_COEF = {`COEF_IDX, 2'h0};
    logic        clock_in = 1'b0;
    logic        resetn_in = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rv, seed = 32'h7EA7;
    logic [3:0]  pstrb = 4'hF, gap = 4'h0;
    logic        pready, pslverr, err, sent = 1'b0, kick = 1'b0;
    logic [5:0]  eng_req = 6'h00, rpt = 6'h00, coef_req;
    logic        eng_init = 1'b0, eng_pre = 1'b0, init_req, pre_req, ovr, rsvd, step, rxf, idle;
    logic [10:0] nfr = 11'h000;
    logic [2:0]  tinc, tdec;
    logic [1:0]  wscale;
    logic [9:0]  wcount;
    logic        wbusy, wdone;
    logic [31:0] win = 32'h5400;
    logic [7:0]  v;
    int          failures = 0, checks = 0, cycles = 0;

    link_training_ber_and_coef_regs i_link_training_ber_and_coef_regs (
        .clock_in(clock_in), .resetn_in(resetn_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .engine_coef_request_in(eng_req), .engine_init_request_in(eng_init),
        .engine_preset_request_in(eng_pre), .frame_sent_in(sent), .sent_report_in(rpt),
        .step_start_in(step), .rx_frame_in(rxf), .coef_request_out(coef_req),
        .init_request_out(init_req), .preset_request_out(pre_req), .override_enable_out(ovr),
        .tap_inc_out(tinc), .tap_dec_out(tdec), .request_reserved_out(rsvd),
        .window_scale_out(wscale), .window_count_out(wcount),
        .window_busy_out(wbusy), .window_done_out(wdone));

    training_engine_model i_training_engine_model (
        .clock_in(clock_in), .resetn_in(resetn_in), .kick_in(kick), .frames_in(nfr),
        .gap_in(gap), .step_start_out(step), .rx_frame_out(rxf), .idle_out(idle));

    always #2.5 clock_in = ~clock_in;

    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            stop_test();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Fresh edge first, so a previous release never meets a new setup in one step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clock_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clock_in);
        penable <= 1'b1;
        @(posedge clock_in);
        while (pready !== 1'b1) begin
            @(posedge clock_in);
        end
        rv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 4'hF);
        check(rv, exp);
    endtask

    // Model: m wins, else k, else raw frame count
    function automatic logic [11:0] eff(input logic [31:0] w);
        if (w[29:20] != 10'h000) return {2'h2, w[29:20]};
        if (w[19:10] != 10'h000) return {2'h1, w[19:10]};
        return {2'h0, w[9:0]};
    endfunction

    task automatic wr_win(input logic [31:0] d, input logic [3:0] s);
        apb(1'b1, A_WIN, d, s);
        for (int b = 0; b < 4; b++) if (s[b]) win[8*b+:8] = d[8*b+:8];
        win[31:30] = 2'h0;
    endtask

    task automatic run_win(input logic [31:0] w, input int n, input logic [3:0] g, input int extra);
        int cnt;
        int dn;
        cnt = 0;
        dn = 0;
        wr_win(w, 4'hF);
        @(posedge clock_in);
        nfr <= 11'(n + extra);
        gap <= g;
        kick <= 1'b1;
        @(posedge clock_in);
        kick <= 1'b0;
        repeat ((n + extra) * (int'(g) + 1) + 20) begin
            @(posedge clock_in);
            if (wdone === 1'b1) begin
                dn++;
                check(cnt, n);
            end
            if (rxf === 1'b1 && cnt == 0) check(wbusy, 1'b1);
            if (rxf === 1'b1) cnt++;
        end
        check(dn, 1);
        check(idle, 1'b1);
    endtask

    initial begin
        repeat (16) @(posedge clock_in);
        resetn_in <= 1'b1;
        rdchk(A_WIN, 32'h5400);
        check({wscale, wcount}, {2'h1, 10'h015});
        check(ovr, 1'b0);
        apb(1'b0, 12'hFFC, 32'h0, 4'hF);
        check(err, 1'b1);
        check(rv, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            if (i % 3 > 0) seed[29:20] = 10'h000;
            if (i % 3 == 2) seed[19:10] = 10'h000;
            wr_win(seed, (i == 5) ? 4'h2 : 4'hF);
            rdchk(A_WIN, win);
            check({wscale, wcount}, eff(win));
        end
        wr_win({2'h0, 10'h003, 10'h3E8, 10'h000}, 4'hF);
        repeat (2) @(posedge clock_in);
        check({wscale, wcount}, {2'h2, 10'h003});
        $display("test window fields done");
        run_win(32'h4, 4, 4'h2, 2);
        run_win(32'h1, 1, 4'h0, 0);
        run_win(32'h400, 1000, 4'h0, 0);
        $display("test window count done");
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            @(posedge clock_in);
            {eng_pre, eng_init, eng_req} <= seed[7:0];
            rpt <= seed[13:8];
            sent <= 1'b1;
            @(posedge clock_in);
            sent <= 1'b0;
            @(posedge clock_in);
            check({pre_req, init_req, coef_req}, seed[7:0]);
            apb(1'b1, A_COEF, 32'hFFFF_FFFF, 4'hF);
            rdchk(A_COEF, {18'h0, seed[13:0]});
        end
        $display("test mirror done");
        apb(1'b1, A_CTL, 32'h0001_0000, 4'hF);
        @(posedge clock_in);
        check(ovr, 1'b1);
        for (int c = 0; c < 4; c++) begin
            v = {2'(c), 2'(c), 2'(c), 2'(c)};
            eng_req <= ~v[5:0];
            apb(1'b1, A_COEF, {18'h0, 6'h3F, v}, 4'hF);
            repeat (2) @(posedge clock_in);
            check({pre_req, init_req, coef_req}, v);
            check({tinc, tdec, rsvd}, {(c == 1) ? 3'h7 : 3'h0, (c == 2) ? 3'h7 : 3'h0, c == 3});
            check(init_req, v[6]);
            check(pre_req, v[7]);
            rdchk(A_COEF, {18'h0, seed[13:8], v});
        end
        apb(1'b1, A_CTL, 32'h0, 4'hF);
        repeat (2) @(posedge clock_in);
        check(coef_req, eng_req);
        $display("test override done");
        stop_test();
    end
endmodule

`default_nettype wire

// ### verification/training_engine_model.sv
`default_nettype none

module training_engine_model (
    input  wire logic        clock_in,
    input  wire logic        resetn_in,
    input  wire logic        kick_in,
    input  wire logic [10:0] frames_in,
    input  wire logic [3:0]  gap_in,
    output logic             step_start_out,
    output logic             rx_frame_out,
    output logic             idle_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int left;
    int gap_cnt;
    // Frames only follow a start; first one waits so the start cycle stays clean
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            left <= 0;
            gap_cnt <= 0;
            step_start_out <= 1'b0;
            rx_frame_out <= 1'b0;
        end else begin
            step_start_out <= kick_in;
            rx_frame_out <= 1'b0;
            if (kick_in) begin
                left <= int'(frames_in);
                gap_cnt <= int'(gap_in) + 1;
            end else if (left > 0) begin
                if (gap_cnt == 0) begin
                    rx_frame_out <= 1'b1;
                    left <= left - 1;
                    gap_cnt <= int'(gap_in);
                end else begin
                    gap_cnt <= gap_cnt - 1;
                end
            end
        end
    end
    assign idle_out = (left == 0);
endmodule

`default_nettype wire
